// file: logic/uifl_pkg.sv
package uifl_pkg;
    localparam logic [11:0] UIFL_OFS_INT_EN   = 12'h00c;
    localparam logic [11:0] UIFL_OFS_INT_FL   = 12'h010;
    localparam logic [11:0] UIFL_OFS_PORT_CTL = 12'h020;
    localparam logic [11:0] UIFL_OFS_STATUS   = 12'h024;
    localparam int UIFL_NUM_FLAGS = 9;
    localparam int UIFL_BIT_FRAME    = 0;
    localparam int UIFL_BIT_PARITY   = 1;
    localparam int UIFL_BIT_CTS      = 2;
    localparam int UIFL_BIT_OVERRUN  = 3;
    localparam int UIFL_BIT_RX_LVL   = 4;
    localparam int UIFL_BIT_TX_AE    = 5;
    localparam int UIFL_BIT_TX_LVL   = 6;
    localparam int UIFL_BIT_BREAK    = 7;
    localparam int UIFL_BIT_RECEIVE_IDLE_TIMEOUT_FLAG    = 8;
    localparam int UIFL_CTL_TX_LSB   = 0;
    localparam int UIFL_CTL_RX_LSB   = 8;
    localparam int UIFL_FIFO_DEPTH   = 8;
    localparam int UIFL_LVL_W        = 4;
    localparam logic [8:0]  UIFL_FLAGS_RESET  = 9'h000;
    localparam logic [8:0]  UIFL_EN_RESET     = 9'h000;
    localparam logic [3:0]  UIFL_TX_LVL_RESET = 4'h0;
    localparam logic [3:0]  UIFL_RX_LVL_RESET = 4'h1;
    localparam logic [3:0]  UIFL_AE_COUNT     = 4'h1;
endpackage

// file: logic/uifl_sticky_bit.sv
`timescale 1ns/1ps
module uifl_sticky_bit
    import uifl_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic set_event,
    input  wire logic clear_one,
    output logic      flag
);
    // Set beats clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flag <= 1'b0;
        end else if (set_event) begin
            flag <= 1'b1;
        end else if (clear_one) begin
            flag <= 1'b0;
        end
    end
endmodule

// file: logic/uifl_break_detect.sv
`timescale 1ns/1ps
module uifl_break_detect
    import uifl_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic break_frame,
    input  wire logic char_frame,
    output logic      first_break
);
    logic in_break_reg;

    // Sequence of breaks ends at first normal character
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            in_break_reg <= 1'b0;
        end else if (break_frame) begin
            in_break_reg <= 1'b1;
        end else if (char_frame) begin
            in_break_reg <= 1'b0;
        end
    end

    assign first_break = break_frame && !in_break_reg;
endmodule

// file: logic/uifl_flags.sv
`timescale 1ns/1ps
// Operation
// R1: A receive frame timeout sets flag bit 8, which stays set until cleared.
// R2: Only the first break frame of a run of breaks sets flag bit 7.
// R3: Flag bit 6 is set while the transmit FIFO count is at or below the transmit threshold.
// R4: The transmit threshold flag sets again at once while its condition holds after a clear.
// R5: Flag bit 5 is set when exactly one byte remains in the transmit FIFO.
// R6: Flag bit 4 is set while the receive FIFO count is at or above the receive threshold.
// R7: The receive threshold flag sets again after a clear while the count stays at threshold.
// R8: Flag bit 3 is set when a character arrives while the receive FIFO is full.
// R9: Flag bit 2 is the CTS change flag, cleared by writing one.
// R10: Flag bit 1 is set by a receive parity error only, never by transmission.
// R11: Flag bit 0 is set by a framing error during reception.
// R12: Every flag is sticky and cleared only by writing one to its bit.
// R13: Any change of the CTS input level raises the CTS flag.
// R14: An enable register at 0x00c gates each flag onto the request output.
// R15: Writing zero leaves a flag unchanged, and all flags are zero after reset.
// R16: A set event in the cycle of a clear wins, so no event is lost.
module uifl_flags
    import uifl_pkg::*;
#(
    parameter int LVL_W = UIFL_LVL_W
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire logic [LVL_W-1:0] tx_fifo_count,
    input  wire logic [LVL_W-1:0] rx_fifo_count,
    input  wire logic             rx_fifo_full,
    input  wire logic             rx_char_valid,
    input  wire logic             rx_timeout,
    input  wire logic             rx_break_frame,
    input  wire logic             rx_parity_error,
    input  wire logic             rx_frame_error,
    input  wire logic             cts_in,
    output logic      [LVL_W-1:0] tx_threshold,
    output logic      [LVL_W-1:0] rx_threshold,
    output logic                  irq_request
);
    logic [UIFL_NUM_FLAGS-1:0] flags;
    logic [UIFL_NUM_FLAGS-1:0] set_vec;
    logic [UIFL_NUM_FLAGS-1:0] clear_vec;
    logic [UIFL_NUM_FLAGS-1:0] enable_reg;
    logic [LVL_W-1:0]          tx_lvl_reg;
    logic [LVL_W-1:0]          rx_lvl_reg;
    logic                      cts_prev_reg;
    logic                      cts_seen_reg;
    logic                      first_break;
    logic                      wr_access;
    logic                      addr_ok;

    assign wr_access = psel && penable && pwrite;
    assign addr_ok   = (paddr == UIFL_OFS_INT_EN) || (paddr == UIFL_OFS_INT_FL)
                    || (paddr == UIFL_OFS_PORT_CTL) || (paddr == UIFL_OFS_STATUS);
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !addr_ok;

    uifl_break_detect u_break (
        .clk         (clk),
        .rst_b       (rst_b),
        .break_frame (rx_break_frame),
        .char_frame  (rx_char_valid),
        .first_break (first_break)
    );

    // CTS level tracker; first sample after reset is not a change
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cts_prev_reg <= 1'b0;
            cts_seen_reg <= 1'b0;
        end else begin
            cts_prev_reg <= cts_in;
            cts_seen_reg <= 1'b1;
        end
    end

    always_comb begin
        set_vec = '0;
        set_vec[UIFL_BIT_RECEIVE_IDLE_TIMEOUT_FLAG]   = rx_timeout;                               // see R1
        set_vec[UIFL_BIT_BREAK]   = first_break;                              // see R2
        set_vec[UIFL_BIT_TX_LVL]  = (tx_fifo_count <= tx_lvl_reg);            // see R3 R4
        set_vec[UIFL_BIT_TX_AE]   = (tx_fifo_count == LVL_W'(UIFL_AE_COUNT)); // see R5
        set_vec[UIFL_BIT_RX_LVL]  = (rx_fifo_count >= rx_lvl_reg);            // see R6 R7
        set_vec[UIFL_BIT_OVERRUN] = rx_char_valid && rx_fifo_full;            // see R8
        set_vec[UIFL_BIT_CTS]     = cts_seen_reg && (cts_in != cts_prev_reg); // see R9 R13
        set_vec[UIFL_BIT_PARITY]  = rx_parity_error;                          // see R10
        set_vec[UIFL_BIT_FRAME]   = rx_frame_error;                           // see R11
    end

    // Write-one-to-clear; zero bits leave flags alone
    assign clear_vec = (wr_access && paddr == UIFL_OFS_INT_FL)
                     ? pwdata[UIFL_NUM_FLAGS-1:0] : '0; // see R12 R15

    genvar gi;
    generate
        for (gi = 0; gi < UIFL_NUM_FLAGS; gi++) begin : g_flag
            uifl_sticky_bit u_bit (
                .clk       (clk),
                .rst_b     (rst_b),
                .set_event (set_vec[gi]),
                .clear_one (clear_vec[gi]),
                .flag      (flags[gi])
            ); // see R12 R15 R16
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            enable_reg <= UIFL_EN_RESET;
        end else if (wr_access && paddr == UIFL_OFS_INT_EN) begin
            enable_reg <= pwdata[UIFL_NUM_FLAGS-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            tx_lvl_reg <= LVL_W'(UIFL_TX_LVL_RESET);
            rx_lvl_reg <= LVL_W'(UIFL_RX_LVL_RESET);
        end else if (wr_access && paddr == UIFL_OFS_PORT_CTL) begin
            tx_lvl_reg <= pwdata[UIFL_CTL_TX_LSB +: LVL_W];
            rx_lvl_reg <= pwdata[UIFL_CTL_RX_LSB +: LVL_W];
        end
    end

    assign tx_threshold = tx_lvl_reg;
    assign rx_threshold = rx_lvl_reg;

    // Request only when flag and enable agree
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irq_request <= 1'b0;
        end else begin
            irq_request <= |(flags & enable_reg); // see R14
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prdata <= '0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= '0;
            case (paddr)
                UIFL_OFS_INT_EN:   prdata[UIFL_NUM_FLAGS-1:0] <= enable_reg;
                UIFL_OFS_INT_FL:   prdata[UIFL_NUM_FLAGS-1:0] <= flags;
                UIFL_OFS_PORT_CTL: begin
                    prdata[UIFL_CTL_TX_LSB +: LVL_W] <= tx_lvl_reg;
                    prdata[UIFL_CTL_RX_LSB +: LVL_W] <= rx_lvl_reg;
                end
                UIFL_OFS_STATUS: begin
                    prdata[0] <= cts_prev_reg;
                end
                default: prdata <= '0;
            endcase
        end
    end
endmodule

// file: sim/uifl_remote.sv
`timescale 1ns/1ps
module uifl_remote (
    input  wire logic       clk,
    input  wire logic [5:0] cmd,
    output logic            rx_frame_error,
    output logic            rx_parity_error,
    output logic            cts_in,
    output logic            rx_char_valid,
    output logic            rx_break_frame,
    output logic            rx_timeout
);
    initial {rx_timeout, rx_break_frame, rx_char_valid, rx_parity_error, rx_frame_error} = '0;
    initial cts_in = 1'b1;
    // One-cycle events; CTS keeps its level between toggles
    always @(posedge clk) begin
        {rx_timeout, rx_break_frame, rx_char_valid} <= cmd[5:3];
        {rx_parity_error, rx_frame_error} <= cmd[1:0];
        cts_in <= cts_in ^ cmd[2];
    end
endmodule

// file: sim/uifl_flags_properties.sv
`timescale 1ns/1ps
module uifl_flags_checker
    import uifl_pkg::*;
#(
    parameter int LVL_W = UIFL_LVL_W
) (
    input wire logic             clk,
    input wire logic             rst_b,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic             pwrite,
    input wire logic [11:0]      paddr,
    input wire logic [31:0]      pwdata,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic [LVL_W-1:0] tx_fifo_count,
    input wire logic [LVL_W-1:0] rx_fifo_count,
    input wire logic             rx_fifo_full,
    input wire logic             rx_char_valid,
    input wire logic             rx_timeout,
    input wire logic             rx_break_frame,
    input wire logic             rx_parity_error,
    input wire logic             rx_frame_error,
    input wire logic             cts_in,
    input wire logic [LVL_W-1:0] tx_threshold,
    input wire logic [LVL_W-1:0] rx_threshold,
    input wire logic             irq_request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic [1:0] run;
    logic       rd;
    always_ff @(posedge clk) run <= {run[0], rst_b};
    // Flag read setup, with the previous edge out of reset
    assign rd = psel && !penable && !pwrite && paddr == UIFL_OFS_INT_FL && run[0];
    a_timeout_sets: assert property (rd && $past(rx_timeout) |=> prdata[UIFL_BIT_RECEIVE_IDLE_TIMEOUT_FLAG])
        else $error("timeout flag missing");
    a_frame_sets: assert property (rd && $past(rx_frame_error) |=> prdata[UIFL_BIT_FRAME])
        else $error("frame flag missing");
    a_parity_sets: assert property (rd && $past(rx_parity_error) |=> prdata[UIFL_BIT_PARITY])
        else $error("parity flag missing");
    a_overrun_sets: assert property (rd && $past(rx_char_valid && rx_fifo_full)
        |=> prdata[UIFL_BIT_OVERRUN]) else $error("overrun flag missing");
    a_txlvl_sets: assert property (rd && $past(tx_fifo_count <= tx_threshold)
        |=> prdata[UIFL_BIT_TX_LVL]) else $error("tx level flag missing");
    a_rxlvl_sets: assert property (rd && $past(rx_fifo_count >= rx_threshold)
        |=> prdata[UIFL_BIT_RX_LVL]) else $error("rx level flag missing");
    a_ae_sets: assert property (rd && $past(tx_fifo_count == UIFL_AE_COUNT)
        |=> prdata[UIFL_BIT_TX_AE]) else $error("almost empty flag missing");
    a_cts_change: assert property (rd && run[1] && $past(cts_in) != $past(cts_in, 2)
        |=> prdata[UIFL_BIT_CTS]) else $error("cts flag missing");
endmodule
bind uifl_flags uifl_flags_checker #(.LVL_W(LVL_W)) i_chk (.clk, .rst_b, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_fifo_count, .rx_fifo_count,
    .rx_fifo_full, .rx_char_valid, .rx_timeout, .rx_break_frame, .rx_parity_error,
    .rx_frame_error, .cts_in, .tx_threshold, .rx_threshold, .irq_request);

// file: sim/uifl_flags_bench.sv
`timescale 1ns/1ps
module uifl_flags_bench
    import uifl_pkg::*;
;
    logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        rx_fifo_full = 1'b1, pready, pslverr, irq_request, err;
    logic        rx_char_valid, rx_timeout, rx_break_frame, rx_parity_error, rx_frame_error, cts_in;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  tx_fifo_count = 4'h5, rx_fifo_count = 4'h0, tx_threshold, rx_threshold;
    logic [5:0]  cmd = 6'h0;
    logic [14:0] rows [7] = '{15'h0201, 15'h0402, 15'h0804, 15'h1008, 15'h2080, 15'h2000, 15'h4100};
    int          n_errors = 0, total_checks = 0, cyc = 0;
    uifl_remote i_remote (.clk, .cmd, .rx_frame_error, .rx_parity_error, .cts_in,
        .rx_char_valid, .rx_break_frame, .rx_timeout);
    uifl_flags i_dut (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .tx_fifo_count, .rx_fifo_count, .rx_fifo_full, .rx_char_valid, .rx_timeout,
        .rx_break_frame, .rx_parity_error, .rx_frame_error, .cts_in, .tx_threshold,
        .rx_threshold, .irq_request);
    initial forever #12.5 clk = ~clk;
    task automatic finish_test;
        if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Far-side events are launched with the setup cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [5:0] c);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata, cmd} <= {1'b1, w, a, d, c};
        @(posedge clk);
        penable <= 1'b1;
        cmd <= 6'h0;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic clr_rd(input logic [31:0] e);
        apb(1'b1, UIFL_OFS_INT_FL, 32'h1ff, 6'h0);
        apb(1'b0, UIFL_OFS_INT_FL, 32'h0, 6'h0);
        chk(rd, e);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            finish_test();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, UIFL_OFS_INT_FL, 32'h0, 6'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, UIFL_OFS_STATUS, 32'h0, rows[i][14:9]);
            apb(1'b1, UIFL_OFS_INT_FL, 32'h0, 6'h0);
            apb(1'b0, UIFL_OFS_INT_FL, 32'h0, 6'h0);
            chk(rd, {23'h0, rows[i][8:0]});
            clr_rd(32'h0);
        end
        apb(1'b1, UIFL_OFS_INT_EN, 32'h1, 6'h0);
        apb(1'b1, UIFL_OFS_INT_FL, 32'h1, 6'h01);
        apb(1'b0, UIFL_OFS_INT_FL, 32'h0, 6'h0);
        chk(rd, 32'h1);
        chk({31'h0, irq_request}, 32'h1);
        clr_rd(32'h0);
        chk({31'h0, irq_request}, 32'h0);
        apb(1'b0, UIFL_OFS_STATUS, 32'h0, 6'h02);
        apb(1'b1, 12'h030, 32'h1ff, 6'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, UIFL_OFS_INT_FL, 32'h0, 6'h0);
        chk(rd, 32'h2);
        chk({31'h0, irq_request}, 32'h0);
        apb(1'b1, UIFL_OFS_PORT_CTL, 32'h105, 6'h0);
        clr_rd(32'h40);
        tx_fifo_count <= 4'h6;
        clr_rd(32'h0);
        apb(1'b1, UIFL_OFS_PORT_CTL, 32'h100, 6'h0);
        tx_fifo_count <= 4'h1;
        clr_rd(32'h20);
        tx_fifo_count <= 4'h2;
        clr_rd(32'h0);
        rx_fifo_count <= 4'h1;
        clr_rd(32'h10);
        rx_fifo_count <= 4'h0;
        clr_rd(32'h0);
        // Events land just before a flag read setup
        cmd <= 6'h2f;
        @(posedge clk);
        cmd <= 6'h0;
        apb(1'b0, UIFL_OFS_INT_FL, 32'h0, 6'h0);
        chk(rd, 32'h10f);
        clr_rd(32'h0);
        apb(1'b0, UIFL_OFS_STATUS, 32'h0, 6'h10);
        apb(1'b0, UIFL_OFS_INT_FL, 32'h0, 6'h0);
        chk(rd, 32'h80);
        rx_fifo_full <= 1'b0;
        apb(1'b0, UIFL_OFS_STATUS, 32'h0, 6'h08);
        apb(1'b0, UIFL_OFS_INT_FL, 32'h0, 6'h0);
        chk(rd, 32'h80);
        apb(1'b1, UIFL_OFS_PORT_CTL, 32'h30f, 6'h0);
        apb(1'b0, UIFL_OFS_PORT_CTL, 32'h0, 6'h0);
        chk(rd, 32'h30f);
        chk({28'h0, tx_threshold}, 32'hf);
        chk({28'h0, rx_threshold}, 32'h3);
        // Reset in mid-run with the level flag set
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, UIFL_OFS_INT_FL, 32'h0, 6'h0);
        chk(rd, 32'h0);
        chk({28'h0, tx_threshold}, 32'h0);
        chk({28'h0, rx_threshold}, 32'h1);
        chk({31'h0, irq_request}, 32'h0);
        finish_test();
    end
endmodule
